// File: hdl/bb_attach_ctrl.sv
// Billboard attach control: failure input, forced detach, detach timers
//
// Overview of operation
// - Failure input active low activates billboard
// - Control bits 5:1 pick pin; 01010 default
// - Control bit 0 enables billboard support
// - Selected pin low forces emulated detach
// - Reattach presenting billboard class descriptors
// - Address set starts first timer, 20 s
// - Billboard only on failure; bmConfigured 00b
// - String request answered, second timer starts
// - Timer expiry: detach, reattach standard identity
// - First timer: 16 bits of 10 ms
// - Failure message comes from OTP content
// - Second timer: own byte pair, 10 ms
`timescale 1ns/1ns
module bb_attach_ctrl import bb_pkg::*; #(
  parameter int TICK_CYCLES = BB_TICK_CYCLES,
  parameter int HOLD_CYCLES = BB_DETACH_HOLD_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire bb_av_req_t av_req,
  output bb_av_rsp_t av_rsp,
  input wire logic [BB_NUM_PINS-1:0] gpio_in,
  input wire bb_func_evt_t func_evt,
  output bb_func_ctl_t func_ctl
);

  typedef enum logic [2:0] {
    BB_S_STANDARD,
    BB_S_DETACH_TO_BB,
    BB_S_BB_WAIT_ADDR,
    BB_S_BB_ADDRESSED,
    BB_S_DETACH_TO_STD
  } bb_state_t;

  // ==========================================================
  // Register storage
  logic [7:0] control_q;
  logic [7:0] tmr_a_lo_q;
  logic [7:0] tmr_a_hi_q;
  logic [7:0] tmr_b_lo_q;
  logic [7:0] tmr_b_hi_q;

  // Bus response flops
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;

  // Pin synchroniser and failure detection
  logic [BB_NUM_PINS-1:0] gpio_meta_q;
  logic [BB_NUM_PINS-1:0] gpio_sync_q;
  logic fail_n_q;
  logic fail_n_d;
  logic fail_event;

  // Sequencer
  bb_state_t state_q;
  bb_state_t state_d;
  logic [15:0] hold_q;
  logic hold_done;

  // Output flops toward the function core
  logic attach_q;
  logic identity_q;
  logic otp_msg_q;
  logic grant_q;

  // Timer hookup
  logic tmr_a_start;
  logic tmr_b_start;
  logic tmr_clear;
  logic tmr_a_run;
  logic tmr_b_run;
  logic tmr_a_exp;
  logic tmr_b_exp;
  logic in_billboard;

  // Bus qualifiers
  logic [15:0] bus_idx;
  logic bus_aligned;
  logic wr_take;
  logic rd_take;
  logic lane0;

  // ==========================================================
  // Helper functions

  // Pin level for a select code; reserved or absent codes read idle high
  function automatic logic pin_for_code(input logic [4:0] code,
                                        input logic [BB_NUM_PINS-1:0] pins);
    logic lvl;
    lvl = 1'b1;
    if (code != BB_SEL_RESERVED && int'(code) < BB_NUM_PINS) begin
      lvl = pins[code];
    end
    return lvl;
  endfunction

  // Register hit test shared by the read and write paths
  function automatic logic reg_hit(input logic [15:0] idx,
                                   input logic [15:0] reg_idx,
                                   input logic aligned);
    return aligned && (idx == reg_idx);
  endfunction

  // ==========================================================
  // Bus request qualifiers
  assign bus_idx = av_req.address[BB_ADDR_W-1:2];
  assign bus_aligned = (av_req.address[1:0] == 2'h0);
  assign lane0 = av_req.byteenable[0];
  // A request completes on the edge where waitrequest is seen low
  assign wr_take = av_req.write && !av_req.read && !waitrequest_q;
  assign rd_take = av_req.read && !av_req.write;

  // One wait state: waitrequest drops for one cycle after a request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitrequest_q <= 1'b1;
    end else if ((av_req.read ^ av_req.write) && waitrequest_q) begin
      waitrequest_q <= 1'b0;
    end else begin
      waitrequest_q <= 1'b1;
    end
  end

  // Read mux; reserved bits and unmapped words read zero
  always_comb begin
    readdata_d = 32'h0000_0000;
    if (reg_hit(bus_idx, BB_IDX_CONTROL, bus_aligned)) begin
      readdata_d[7:0] = control_q;
    end else if (reg_hit(bus_idx, BB_IDX_TMR_A_LO, bus_aligned)) begin
      readdata_d[7:0] = tmr_a_lo_q;
    end else if (reg_hit(bus_idx, BB_IDX_TMR_A_HI, bus_aligned)) begin
      readdata_d[7:0] = tmr_a_hi_q;
    end else if (reg_hit(bus_idx, BB_IDX_TMR_B_LO, bus_aligned)) begin
      readdata_d[7:0] = tmr_b_lo_q;
    end else if (reg_hit(bus_idx, BB_IDX_TMR_B_HI, bus_aligned)) begin
      readdata_d[7:0] = tmr_b_hi_q;
    end else if (reg_hit(bus_idx, BB_IDX_STATUS, bus_aligned)) begin
      readdata_d[BB_ST_ATTACHED_BIT] = attach_q;
      readdata_d[BB_ST_IDENTITY_BIT] = identity_q;
      readdata_d[BB_ST_TMR_A_BIT] = tmr_a_run;
      readdata_d[BB_ST_TMR_B_BIT] = tmr_b_run;
      readdata_d[BB_ST_FAIL_N_BIT] = fail_n_q;
    end
  end

  // Read data captured with the waitrequest drop, held for the sample edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (rd_take && waitrequest_q) begin
      readdata_q <= readdata_d;
    end
  end

  // ==========================================================
  // Control register; upper two bits are kept at zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_q <= BB_CONTROL_RST;
    end else if (wr_take && lane0 &&
                 reg_hit(bus_idx, BB_IDX_CONTROL, bus_aligned)) begin
      control_q <= {2'h0, av_req.writedata[BB_CTL_USED_MSB:0]};
    end
  end

  // Timer limit bytes, low and high halves of each 16-bit count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmr_a_lo_q <= BB_TMR_LO_RST;
      tmr_a_hi_q <= BB_TMR_HI_RST;
      tmr_b_lo_q <= BB_TMR_LO_RST;
      tmr_b_hi_q <= BB_TMR_HI_RST;
    end else if (wr_take && lane0) begin
      if (reg_hit(bus_idx, BB_IDX_TMR_A_LO, bus_aligned)) begin
        tmr_a_lo_q <= av_req.writedata[7:0];
      end else if (reg_hit(bus_idx, BB_IDX_TMR_A_HI, bus_aligned)) begin
        tmr_a_hi_q <= av_req.writedata[7:0];
      end else if (reg_hit(bus_idx, BB_IDX_TMR_B_LO, bus_aligned)) begin
        tmr_b_lo_q <= av_req.writedata[7:0];
      end else if (reg_hit(bus_idx, BB_IDX_TMR_B_HI, bus_aligned)) begin
        tmr_b_hi_q <= av_req.writedata[7:0];
      end
    end
  end

  // ==========================================================
  // Two-flop synchroniser on every candidate pin
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gpio_meta_q <= '1;
      gpio_sync_q <= '1;
    end else begin
      gpio_meta_q <= gpio_in;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  // Selected failure line, active low
  assign fail_n_d = pin_for_code(control_q[BB_CTL_SEL_MSB:BB_CTL_SEL_LSB],
                                 gpio_sync_q);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fail_n_q <= 1'b1;
    end else begin
      fail_n_q <= fail_n_d;
    end
  end

  // Falling edge only, so a line held low does not loop the sequence
  assign fail_event = fail_n_q && !fail_n_d &&
                      control_q[BB_CTL_EN_BIT];

  // ==========================================================
  // Detach hold counter, restarted on entry to each detach state
  assign hold_done = (hold_q == 16'(HOLD_CYCLES - 1));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_q <= 16'h0000;
    end else if (state_q != state_d) begin
      hold_q <= 16'h0000;
    end else if (!hold_done) begin
      hold_q <= hold_q + 16'h0001;
    end
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      BB_S_STANDARD: begin
        if (fail_event) begin
          state_d = BB_S_DETACH_TO_BB;
        end
      end
      BB_S_DETACH_TO_BB: begin
        if (hold_done) begin
          state_d = BB_S_BB_WAIT_ADDR;
        end
      end
      BB_S_BB_WAIT_ADDR: begin
        if (func_evt.addr_set) begin
          state_d = BB_S_BB_ADDRESSED;
        end
      end
      BB_S_BB_ADDRESSED: begin
        if (tmr_a_exp || tmr_b_exp) begin
          state_d = BB_S_DETACH_TO_STD;
        end
      end
      BB_S_DETACH_TO_STD: begin
        if (hold_done) begin
          state_d = BB_S_STANDARD;
        end
      end
      default: begin
        state_d = BB_S_STANDARD;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= BB_S_STANDARD;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Timer control
  assign in_billboard = (state_q == BB_S_BB_WAIT_ADDR) ||
                        (state_q == BB_S_BB_ADDRESSED);
  assign tmr_a_start = (state_q == BB_S_BB_WAIT_ADDR) &&
                       func_evt.addr_set;
  // Every string request in the addressed state restarts the second timer, except one in the cycle a timer expires
  assign tmr_b_start = (state_q == BB_S_BB_ADDRESSED) &&
                       func_evt.alt_string_req &&
                       !(tmr_a_exp || tmr_b_exp);
  assign tmr_clear = (state_q == BB_S_DETACH_TO_STD);

  bb_detach_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(tmr_a_start),
    .clear(tmr_clear),
    .limit({tmr_a_hi_q, tmr_a_lo_q}),
    .running(tmr_a_run),
    .expired(tmr_a_exp)
  );

  bb_detach_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(tmr_b_start),
    .clear(tmr_clear),
    .limit({tmr_b_hi_q, tmr_b_lo_q}),
    .running(tmr_b_run),
    .expired(tmr_b_exp)
  );

  // ==========================================================
  // Outputs toward the function core, registered except the constant bm_configured
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      attach_q <= 1'b1;
    end else begin
      // Off the port while either detach state runs
      attach_q <= (state_d != BB_S_DETACH_TO_BB) &&
                  (state_d != BB_S_DETACH_TO_STD);
    end
  end

  // Identity switches only while detached, never under the host's feet
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      identity_q <= 1'b0;
      otp_msg_q <= 1'b0;
    end else if (state_d == BB_S_DETACH_TO_BB) begin
      identity_q <= 1'b1;
      otp_msg_q <= 1'b1;
    end else if (state_d == BB_S_DETACH_TO_STD) begin
      identity_q <= 1'b0;
      otp_msg_q <= 1'b0;
    end
  end

  // One-cycle grant that the string may be returned
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      grant_q <= 1'b0;
    end else begin
      grant_q <= in_billboard && func_evt.alt_string_req;
    end
  end

  assign av_rsp.readdata = readdata_q;
  assign av_rsp.waitrequest = waitrequest_q;
  assign func_ctl.attach = attach_q;
  assign func_ctl.bb_identity = identity_q;
  assign func_ctl.otp_msg_en = otp_msg_q;
  assign func_ctl.bm_configured = BB_CFG_UNSPEC_ERR;
  assign func_ctl.alt_string_grant = grant_q;

endmodule

// File: hdl/bb_detach_timer.sv
// Detach timer counting a 16-bit limit in fixed ticks
`timescale 1ns/1ns
module bb_detach_timer import bb_pkg::*; #(
  parameter int TICK_CYCLES = BB_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic clear,
  input wire logic [15:0] limit,
  output logic running,
  output logic expired
);

  logic [31:0] pre_q;
  logic [15:0] ticks_q;
  logic [15:0] limit_q;
  logic run_q;
  logic exp_q;
  logic tick;

  assign tick = run_q && (pre_q == 32'(TICK_CYCLES - 1));
  assign running = run_q;
  assign expired = exp_q;

  // ==========================================================
  // Prescaler restarts with each start so the first tick is full length
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 32'h0000_0000;
    end else if (clear || start || tick) begin
      pre_q <= 32'h0000_0000;
    end else if (run_q) begin
      pre_q <= pre_q + 32'h0000_0001;
    end
  end

  // Tick counter; limit latched at start so later writes do not disturb it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ticks_q <= 16'h0000;
      limit_q <= 16'h0000;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_q <= 1'b0;
      if (clear) begin
        ticks_q <= 16'h0000;
        run_q <= 1'b0;
      end else if (start) begin
        ticks_q <= 16'h0000;
        limit_q <= limit;
        run_q <= 1'b1;
      end else if (tick) begin
        // A zero limit expires on the first tick
        if (ticks_q + 16'h0001 >= limit_q) begin
          run_q <= 1'b0;
          exp_q <= 1'b1;
        end
        ticks_q <= ticks_q + 16'h0001;
      end
    end
  end

endmodule

// File: hdl/bb_pkg.sv
// Package: constants, register map and carrier types of the attach control
package bb_pkg;

  // ==========================================================
  // Clock and time base
  localparam int BB_CLK_PERIOD_NS = 4;
  localparam int BB_TICK_MS = 10;
  localparam int BB_TICK_CYCLES = BB_TICK_MS * 1000000 / BB_CLK_PERIOD_NS;
  // Time the internal function stays off the port in an emulated detach
  localparam int BB_DETACH_HOLD_US = 10;
  localparam int BB_DETACH_HOLD_CYCLES =
    (BB_DETACH_HOLD_US * 1000 + BB_CLK_PERIOD_NS - 1) / BB_CLK_PERIOD_NS;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [15:0] BB_IDX_CONTROL = 16'h0004;
  localparam logic [15:0] BB_IDX_TMR_A_LO = 16'h413C;
  localparam logic [15:0] BB_IDX_TMR_A_HI = 16'h413D;
  localparam logic [15:0] BB_IDX_TMR_B_LO = 16'h413E;
  localparam logic [15:0] BB_IDX_TMR_B_HI = 16'h413F;
  localparam logic [15:0] BB_IDX_STATUS = 16'h4180;

  // Reset values
  localparam logic [7:0] BB_CONTROL_RST = 8'h14;
  localparam logic [7:0] BB_TMR_LO_RST = 8'hD0;
  localparam logic [7:0] BB_TMR_HI_RST = 8'h07;

  // Control fields
  localparam int BB_CTL_EN_BIT = 0;
  localparam int BB_CTL_SEL_LSB = 1;
  localparam int BB_CTL_SEL_MSB = 5;
  localparam int BB_CTL_USED_MSB = 5;
  localparam logic [4:0] BB_SEL_DEFAULT = 5'h0A;
  localparam logic [4:0] BB_SEL_RESERVED = 5'h09;
  localparam int BB_NUM_PINS = 17;

  // Status fields
  localparam int BB_ST_ATTACHED_BIT = 0;
  localparam int BB_ST_IDENTITY_BIT = 1;
  localparam int BB_ST_TMR_A_BIT = 2;
  localparam int BB_ST_TMR_B_BIT = 3;
  localparam int BB_ST_FAIL_N_BIT = 4;

  // Descriptor field value: unspecified error
  localparam logic [1:0] BB_CFG_UNSPEC_ERR = 2'h0;

  // ==========================================================
  // Bus geometry and carriers
  localparam int BB_ADDR_W = 18;

  typedef struct packed {
    logic read;
    logic write;
    logic [BB_ADDR_W-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bb_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } bb_av_rsp_t;

  // Events from the internal function core
  typedef struct packed {
    logic addr_set;
    logic alt_string_req;
  } bb_func_evt_t;

  // Steering toward the internal function core
  typedef struct packed {
    logic attach;
    logic bb_identity;
    logic otp_msg_en;
    logic [1:0] bm_configured;
    logic alt_string_grant;
  } bb_func_ctl_t;

endpackage

// File: hdl/placeholder_none.sv
`timescale 1ns/1ns

// File: testbench/bb_attach_ctrl_asserts.sv
// Checker: port-level properties of the attach control
`timescale 1ns/1ns
module bb_chk import bb_pkg::*; #(
  parameter int TICK_CYCLES = 4,
  parameter int HOLD_CYCLES = 3
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire bb_av_req_t av_req,
  input wire bb_av_rsp_t av_rsp,
  input wire logic [BB_NUM_PINS-1:0] gpio_in,
  input wire bb_func_evt_t func_evt,
  input wire bb_func_ctl_t func_ctl
);
  // ==========================================
  // Single domain, silenced in reset
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Bus answers: one wait state, never unasked
  chk_wait_one: assert property (!av_rsp.waitrequest |=> av_rsp.waitrequest)
    else $error("wait low more than one cycle");
  chk_req_answer: assert property ($fell(av_rsp.waitrequest)
    |-> $past(av_req.read ^ av_req.write))
    else $error("answer without request");
  chk_no_answer: assert property (av_rsp.waitrequest
    && !(av_req.read ^ av_req.write) |=> av_rsp.waitrequest)
    else $error("answer to idle or bad request");

  // Length of the current detach; a counter, since the hold is long
  int det_len_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      det_len_q <= 0;
    end else if (!func_ctl.attach) begin
      det_len_q <= det_len_q + 1;
    end else begin
      det_len_q <= 0;
    end
  end

  // Detach: low exactly the hold time, never longer
  chk_detach_hold: assert property ($rose(func_ctl.attach)
    |-> det_len_q == HOLD_CYCLES)
    else $error("detach hold wrong");
  chk_detach_max: assert property (det_len_q <= HOLD_CYCLES)
    else $error("detach longer than hold");
  // Identity only swaps while detached
  chk_ident_swap: assert property ($changed(func_ctl.bb_identity)
    |-> !func_ctl.attach)
    else $error("identity changed while attached");
  chk_cfg_err: assert property (func_ctl.bm_configured == 2'h0)
    else $error("configured field not unspecified");
  chk_otp_msg: assert property (func_ctl.bb_identity
    |-> func_ctl.otp_msg_en)
    else $error("message not from otp");
  chk_grant_req: assert property (func_evt.alt_string_req
    && func_ctl.bb_identity && func_ctl.attach
    |=> func_ctl.alt_string_grant)
    else $error("string request not granted");
  chk_grant_cause: assert property (func_ctl.alt_string_grant
    |-> $past(func_evt.alt_string_req))
    else $error("grant without request");
endmodule

bind bb_attach_ctrl bb_chk #(.TICK_CYCLES(TICK_CYCLES),
  .HOLD_CYCLES(HOLD_CYCLES)) chk_u (.sys_clk(sys_clk), .rst(rst),
  .av_req(av_req), .av_rsp(av_rsp), .gpio_in(gpio_in),
  .func_evt(func_evt), .func_ctl(func_ctl));

// File: testbench/bb_host_model.sv
// Far side model: fail line of the PD controller and USB host events
`timescale 1ns/1ns
module bb_host_model import bb_pkg::*; (
  input wire logic sys_clk,
  output logic [BB_NUM_PINS-1:0] gpio_in,
  output bb_func_evt_t func_evt,
  input wire bb_func_ctl_t func_ctl
);
  // ==========================================
  // Pins have pull-ups, so idle reads high
  initial begin
    gpio_in = '1;
    func_evt = '0;
  end

  // Active-low failure report on one pin
  task automatic pin(input int idx, input logic v);
    @(posedge sys_clk);
    gpio_in[idx] <= v;
  endtask

  // Host assigns the function address
  task automatic addr();
    @(posedge sys_clk);
    func_evt.addr_set <= 1'b1;
    @(posedge sys_clk);
    func_evt.addr_set <= 1'b0;
  endtask

  // Host asks for the string; grant seen one cycle later
  task automatic str(output logic g);
    @(posedge sys_clk);
    func_evt.alt_string_req <= 1'b1;
    @(posedge sys_clk);
    func_evt.alt_string_req <= 1'b0;
    @(posedge sys_clk);
    g = func_ctl.alt_string_grant;
  endtask
endmodule

// File: testbench/tb.sv
// Testbench: attach control against the host model
`timescale 1ns/1ns
module tb import bb_pkg::*;;
  logic sys_clk;
  logic rst;
  bb_av_req_t av_req;
  bb_av_rsp_t av_rsp;
  logic [BB_NUM_PINS-1:0] gpio_in;
  bb_func_evt_t func_evt;
  bb_func_ctl_t func_ctl;
  int failures;
  int cmp_count;
  int cyc;
  int low_cnt;
  int n;
  logic g;
  logic [3:0] be;
  logic [1:0] off;

  // Short tick and hold keep the run brief
  bb_attach_ctrl #(.TICK_CYCLES(4), .HOLD_CYCLES(3)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
    .gpio_in(gpio_in), .func_evt(func_evt), .func_ctl(func_ctl));
  bb_host_model host_u (.sys_clk(sys_clk), .gpio_in(gpio_in),
    .func_evt(func_evt), .func_ctl(func_ctl));

  // ==========================================
  // Clock, watchdog and detach counter
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (!func_ctl.attach) low_cnt++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // ==========================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus cycle; holds until wait state ends
  task automatic bus(input logic wr, input logic [15:0] idx,
    input logic [7:0] wd, output logic [31:0] rd);
    int k;
    k = 0;
    av_req <= '{read: !wr, write: wr, address: {idx, off},
      writedata: {24'h0, wd}, byteenable: be};
    do begin
      @(posedge sys_clk);
      k++;
    end while (av_rsp.waitrequest !== 1'b0 && k < 100);
    rd = av_rsp.readdata;
    if (k >= 100) failures++;
    av_req <= '0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rchk(input string nm, input logic [15:0] idx,
    input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, idx, 8'h00, r);
    check(nm, r, {24'h0, e});
  endtask

  // Bounded wait for the attach level
  task automatic wait_att(input logic v, output int k);
    k = 0;
    while (func_ctl.attach !== v && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 2000) failures++;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_regs();
    rchk("ctl", 16'h0004, 8'h14);
    rchk("a_lo", 16'h413C, 8'hD0);
    rchk("a_hi", 16'h413D, 8'h07);
    rchk("b_lo", 16'h413E, 8'hD0);
    rchk("b_hi", 16'h413F, 8'h07);
    rchk("unmapped", 16'h0100, 8'h00);
    wr(16'h0004, 8'hD3);
    rchk("ctl_top", 16'h0004, 8'h13);
    // Lane 0 off and an unaligned address must both be dropped
    be = 4'hE;
    wr(16'h0004, 8'h00);
    be = 4'hF;
    off = 2'h1;
    wr(16'h0004, 8'h00);
    rchk("unaligned", 16'h0004, 8'h00);
    off = 2'h0;
    rchk("ctl_keep", 16'h0004, 8'h13);
    check("idle_attach", func_ctl.attach, 1'b1);
    $display("test regs done");
  endtask

  // Fail line low with support off, then on the reserved code
  task automatic t_ignored();
    wr(16'h0004, 8'h14);
    host_u.pin(10, 1'b0);
    repeat (30) @(posedge sys_clk);
    check("off_attach", func_ctl.attach, 1'b1);
    host_u.pin(10, 1'b1);
    wr(16'h0004, 8'h13);
    host_u.pin(9, 1'b0);
    repeat (30) @(posedge sys_clk);
    check("rsv_attach", func_ctl.attach, 1'b1);
    host_u.pin(9, 1'b1);
    repeat (6) @(posedge sys_clk);
    $display("test ignored done");
  endtask

  // Default pin, addressed, first timer of two ticks
  task automatic t_first();
    wr(16'h413C, 8'h02);
    wr(16'h413D, 8'h00);
    wr(16'h0004, 8'h15);
    host_u.pin(10, 1'b0);
    wait_att(1'b0, n);
    check("det_time", n <= 8, 1);
    wait_att(1'b1, n);
    check("bb_ident", func_ctl.bb_identity, 1'b1);
    check("otp", func_ctl.otp_msg_en, 1'b1);
    check("cfg", func_ctl.bm_configured, 2'h0);
    host_u.pin(10, 1'b1);
    host_u.addr();
    wait_att(1'b0, n);
    check("a_time", n >= 6 && n <= 16, 1);
    wait_att(1'b1, n);
    check("std_ident", func_ctl.bb_identity, 1'b0);
    repeat (4) @(posedge sys_clk);
    rchk("status", 16'h4180, 8'h11);
    $display("test first done");
  endtask

  // Pin three, string request, second timer beats the first
  task automatic t_second();
    wr(16'h413C, 8'h00);
    wr(16'h413D, 8'h01);
    wr(16'h413E, 8'h03);
    wr(16'h413F, 8'h00);
    wr(16'h0004, 8'h07);
    host_u.pin(3, 1'b0);
    wait_att(1'b0, n);
    wait_att(1'b1, n);
    check("bb_ident", func_ctl.bb_identity, 1'b1);
    host_u.pin(3, 1'b1);
    host_u.addr();
    host_u.str(g);
    check("grant", g, 1'b1);
    wait_att(1'b0, n);
    check("b_time", n >= 6 && n <= 20, 1);
    wait_att(1'b1, n);
    check("std_ident", func_ctl.bb_identity, 1'b0);
    rchk("status", 16'h4180, 8'h11);
    // First timer would fire near 1024 cycles if left running
    low_cnt = 0;
    repeat (1100) @(posedge sys_clk);
    check("no_late", low_cnt, 0);
    $display("test second done");
  endtask

  // ==========================================
  // Verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    av_req = '0;
    be = 4'hF;
    off = 2'h0;
    failures = 0;
    cmp_count = 0;
    cyc = 0;
    low_cnt = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs();
    t_ignored();
    t_first();
    t_second();
    end_of_test();
  end
endmodule
